/* File: rtl/ascc_pkg.sv */
/*
  Shared constants for the converter sample/convert control block.
  Assumes a 32-bit AHB-Lite register bus with word-aligned accesses.
*/
package ascc_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses within the block)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CTRL_CLR = 8'h04;
  localparam logic [7:0] OFS_CTRL_SET = 8'h08;
  localparam logic [7:0] OFS_CTRL_INV = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_CONV_CFG = 8'h18;
  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int BIT_DONE = 0;
  localparam int BIT_SAMPLE_ENABLE = 1;
  localparam int BIT_AUTO = 2;
  localparam int BIT_STOP = 4;
  localparam int BIT_TRIG_LO = 5;
  localparam int BIT_ON = 15;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_80f6;
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SEQ = 1;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] SEQ_LEN_RESET = 4'h1;
  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_NS = 120;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CNT_W = 8;
  // States of the sequencer
  typedef enum logic [1:0] {ASCC_IDLE, ASCC_SAMPLE, ASCC_CONVERT} ascc_state_e;
endpackage : ascc_pkg

/* File: rtl/ascc_sync.sv */
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to hclk.
*/
`timescale 1ns/10ps
module ascc_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Data
  input wire logic din,
  output logic dout
);
  logic stage1;

  // Two flip-flop chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : ascc_sync

/* File: rtl/ascc_ctrl.sv */
/*
  Sample and conversion sequencing control of a successive-approximation
  converter, with its control register, alias registers and interrupt.
  Assumes an AHB-Lite master on hclk and an external trigger pin.
*/
// Behaviour
// - Stop option set: first sequence interrupt clears auto sample start.
// - Stop option clear: sequences keep running, results overwritten.
// - Auto start set: sampling restarts after conversion, sample bit set.
// - Auto start clear: sampling starts only on software writing sample bit.
// - Sample bit reads 1 while acquiring, 0 while holding.
// - Manual trigger: software writing sample bit 0 starts conversion.
// - Nonzero trigger source: hardware clears sample bit when trigger fires.
// - Done bit set when conversion completes; 0 before any.
// - Software clears done by writing 0; clearing leaves operation alone.
// - Done bit cleared automatically when a new conversion starts.
// - Control bit 3 unimplemented, reads zero.
// - Clear, set, invert aliases at offsets 0x4, 0x8, 0xC.
`timescale 1ns/10ps
module ascc_ctrl (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter pins
  input wire logic trigger_in,
  output logic sampling,
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [3:0] seq_len;
  logic [3:0] seq_cnt;
  localparam int CNT_W = ascc_pkg::CONV_CNT_W;
  logic [CNT_W-1:0] conv_cnt;
  ascc_pkg::ascc_state_e state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic trig_sync;
  logic trig_prev;
  logic trig_rise;
  logic conv_done;
  logic seq_end;
  logic conv_start;
  logic [31:0] wr_data;
  logic [31:0] next_ctrl;
  logic sw_sample_enable_set;
  logic sw_sample_enable_clr;
  logic sw_done_clr;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(ascc_pkg::CONV_CYCLES - 1);
  // Cycles from the first converting cycle to the completion strobe
  localparam int CONV_WAIT_I = ascc_pkg::CONV_CYCLES - 1;
  localparam int IRQ_SEQ_I = ascc_pkg::IRQ_SEQ;

  // ----------------------------------------------------------------
  // Trigger input synchroniser and edge detect
  // ----------------------------------------------------------------
  ascc_sync u_trig_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(trigger_in),
    .dout(trig_sync)
  );

  // Previous synchronised trigger level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_sync;
    end
  end

  assign trig_rise = trig_sync & ~trig_prev;

  // ----------------------------------------------------------------
  // AHB-Lite address phase capture; writes land one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel & hready & htrans[1] & hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data registered in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        ascc_pkg::OFS_CTRL: hrdata <= ctrl;
        ascc_pkg::OFS_IRQ_STAT: hrdata <= {30'h0000_0000, irq_stat};
        ascc_pkg::OFS_IRQ_MASK: hrdata <= {30'h0000_0000, irq_mask};
        ascc_pkg::OFS_CONV_CFG: hrdata <= {28'h000_0000, seq_len};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register write decode, with alias operations
  // ----------------------------------------------------------------
  always_comb begin
    wr_data = ctrl;
    if (wr_pend) begin
      case (wr_addr)
        ascc_pkg::OFS_CTRL: wr_data = hwdata;
        ascc_pkg::OFS_CTRL_CLR: wr_data = ctrl & ~hwdata;
        ascc_pkg::OFS_CTRL_SET: wr_data = ctrl | hwdata;
        ascc_pkg::OFS_CTRL_INV: wr_data = ctrl ^ hwdata;
        default: wr_data = ctrl;
      endcase
    end
  end

  // Software effects on the handshake bits
  always_comb begin
    sw_sample_enable_set = 1'b0;
    sw_sample_enable_clr = 1'b0;
    sw_done_clr = 1'b0;
    if (wr_data != ctrl || (wr_pend && wr_addr[7:4] == 4'h0)) begin
      sw_sample_enable_set = ~ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] & wr_data[ascc_pkg::BIT_SAMPLE_ENABLE];
      sw_sample_enable_clr = ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] & ~wr_data[ascc_pkg::BIT_SAMPLE_ENABLE]
                    & (ctrl[7:5] == ascc_pkg::TRIG_MANUAL);
      sw_done_clr = ~wr_data[ascc_pkg::BIT_DONE];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer events
  // ----------------------------------------------------------------
  assign conv_done = (state == ascc_pkg::ASCC_CONVERT) && (conv_cnt == CONV_LAST);
  assign seq_end = conv_done && (seq_cnt == seq_len - 4'h1);
  always_comb begin
    conv_start = 1'b0;
    if (state == ascc_pkg::ASCC_SAMPLE && ctrl[ascc_pkg::BIT_ON]) begin
      if (ctrl[7:5] == ascc_pkg::TRIG_MANUAL) begin
        conv_start = sw_sample_enable_clr;
      end else begin
        conv_start = trig_rise;
      end
    end
  end

  // Next control value: software fields, then hardware overrides
  always_comb begin
    next_ctrl = (wr_data & ascc_pkg::CTRL_WMASK) | (ctrl & ~ascc_pkg::CTRL_WMASK);
    next_ctrl[ascc_pkg::BIT_DONE] = ctrl[ascc_pkg::BIT_DONE] & ~sw_done_clr;
    next_ctrl[3] = 1'b0;
    next_ctrl[31:16] = 16'h0000;
    next_ctrl[14:8] = 7'h00;
    // Sample bit follows the sequencer, not the raw write
    next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] = ctrl[ascc_pkg::BIT_SAMPLE_ENABLE];
    if (sw_sample_enable_set && !ctrl[ascc_pkg::BIT_AUTO] && state == ascc_pkg::ASCC_IDLE) begin
      next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] = 1'b1;
    end
    if (conv_start) begin
      next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] = 1'b0;
      next_ctrl[ascc_pkg::BIT_DONE] = 1'b0;
    end
    if (conv_done) begin
      next_ctrl[ascc_pkg::BIT_DONE] = 1'b1;
      if (ctrl[ascc_pkg::BIT_AUTO] && !(seq_end && ctrl[ascc_pkg::BIT_STOP])) begin
        next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] = 1'b1;
      end
    end
    if (seq_end && ctrl[ascc_pkg::BIT_STOP]) begin
      next_ctrl[ascc_pkg::BIT_AUTO] = 1'b0;
    end
    if (!next_ctrl[ascc_pkg::BIT_ON]) begin
      next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] = 1'b0;
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= ascc_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ascc_pkg::ASCC_IDLE;
    end else if (!next_ctrl[ascc_pkg::BIT_ON]) begin
      // Follows the enable as it is written, so state and sample bit agree
      state <= ascc_pkg::ASCC_IDLE;
    end else begin
      case (state)
        ascc_pkg::ASCC_IDLE: begin
          if (next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE]) begin
            state <= ascc_pkg::ASCC_SAMPLE;
          end
        end
        ascc_pkg::ASCC_SAMPLE: begin
          if (conv_start) begin
            state <= ascc_pkg::ASCC_CONVERT;
          end
        end
        ascc_pkg::ASCC_CONVERT: begin
          if (conv_done) begin
            state <= next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] ? ascc_pkg::ASCC_SAMPLE
                                                   : ascc_pkg::ASCC_IDLE;
          end
        end
        default: state <= ascc_pkg::ASCC_IDLE;
      endcase
    end
  end

  // Conversion cycle counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_cnt <= '0;
    end else if (state != ascc_pkg::ASCC_CONVERT || conv_done) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= conv_cnt + CNT_W'(1);
    end
  end

  // Conversions per sequence; wraps to overwrite earlier results
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_cnt <= 4'h0;
    end else if (!ctrl[ascc_pkg::BIT_ON] || seq_end) begin
      seq_cnt <= 4'h0;
    end else if (conv_done) begin
      seq_cnt <= seq_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Sequence length, interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_len <= ascc_pkg::SEQ_LEN_RESET;
      irq_mask <= 2'h0;
    end else if (wr_pend) begin
      if (wr_addr == ascc_pkg::OFS_CONV_CFG) begin
        seq_len <= (hwdata[3:0] == 4'h0) ? 4'h1 : hwdata[3:0];
      end
      if (wr_addr == ascc_pkg::OFS_IRQ_MASK) begin
        irq_mask <= hwdata[1:0];
      end
    end
  end

  // Sticky status: hardware set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_pend && wr_addr == ascc_pkg::OFS_IRQ_STAT) ? hwdata[1:0] : 2'h0))
                  | {seq_end, conv_done};
    end
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      sampling <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
      sampling <= next_ctrl[ascc_pkg::BIT_SAMPLE_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_seq_end_stop;
    seq_end && ctrl[ascc_pkg::BIT_STOP];
  endsequence
  property p_stop_clears_auto;
    @(posedge hclk) disable iff (!hresetn) s_seq_end_stop |=> !ctrl[ascc_pkg::BIT_AUTO];
  endproperty
  a_stop_clears_auto: assert property (p_stop_clears_auto) else $error("auto start not cleared");
  property p_auto_restart;
    @(posedge hclk) disable iff (!hresetn)
      conv_done && ctrl[ascc_pkg::BIT_AUTO] && !ctrl[ascc_pkg::BIT_STOP] && next_ctrl[ascc_pkg::BIT_ON]
      |=> ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] && state == ascc_pkg::ASCC_SAMPLE;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("no auto restart");
  property p_no_self_start;
    @(posedge hclk) disable iff (!hresetn)
      state == ascc_pkg::ASCC_IDLE && !ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] && !wr_pend |=> !ctrl[ascc_pkg::BIT_SAMPLE_ENABLE];
  endproperty
  a_no_self_start: assert property (p_no_self_start) else $error("sampling began unasked");
  property p_sample_enable_state;
    @(posedge hclk) disable iff (!hresetn) ctrl[ascc_pkg::BIT_SAMPLE_ENABLE] == (state == ascc_pkg::ASCC_SAMPLE);
  endproperty
  a_sample_enable_state: assert property (p_sample_enable_state) else $error("sample bit mismatch");
  property p_manual_conv;
    @(posedge hclk) disable iff (!hresetn)
      state == ascc_pkg::ASCC_SAMPLE && sw_sample_enable_clr && ctrl[ascc_pkg::BIT_ON] && next_ctrl[ascc_pkg::BIT_ON]
      |=> state == ascc_pkg::ASCC_CONVERT;
  endproperty
  a_manual_conv: assert property (p_manual_conv) else $error("manual conversion missed");
  property p_trig_conv;
    @(posedge hclk) disable iff (!hresetn)
      ctrl[7:5] != ascc_pkg::TRIG_MANUAL && state == ascc_pkg::ASCC_SAMPLE && trig_rise && ctrl[ascc_pkg::BIT_ON]
      |=> !ctrl[ascc_pkg::BIT_SAMPLE_ENABLE];
  endproperty
  a_trig_conv: assert property (p_trig_conv) else $error("trigger did not end sampling");
  property p_conv_len;
    @(posedge hclk) disable iff (!hresetn)
      $rose(state == ascc_pkg::ASCC_CONVERT) |-> ##CONV_WAIT_I conv_done ##1 ctrl[ascc_pkg::BIT_DONE];
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("done not set after conversion");
  property p_done_clr_start;
    @(posedge hclk) disable iff (!hresetn) conv_start |=> !ctrl[ascc_pkg::BIT_DONE];
  endproperty
  a_done_clr_start: assert property (p_done_clr_start) else $error("done kept at start");
  property p_bit3_zero;
    @(posedge hclk) disable iff (!hresetn) !ctrl[3];
  endproperty
  a_bit3_zero: assert property (p_bit3_zero) else $error("bit 3 set");
  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn) seq_end && irq_mask[IRQ_SEQ_I] |=> ##1 irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule : ascc_ctrl

/* File: test/tb.sv */
/*
  Self-checking bench for the converter sample/convert control block.
  Assumes the block answers AHB-Lite with zero wait states and that
  the trigger pin is sampled through a short synchroniser.
*/
`timescale 1ns/10ps
`define CHK(what, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); \
  end \
end
module tb;
  // ----------------------------------------------------------------
  // Signals and clock
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic trigger_in = 1'b0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic sampling;
  logic irq;
  int mismatches = 0;
  int n_compared = 0;

  // Free-running 100 MHz clock
  always #5 hclk = ~hclk;

  // The one slave drives the bus ready
  assign hready = hreadyout;

  ascc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in), .sampling(sampling), .irq(irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // A wait that ran out counts as a mismatch and closes the run
  task timed_out(input string what);
    mismatches++;
    $display("unexpected timeout on %s: expected 1, seen 0", what);
    report_and_stop();
  endtask : timed_out

  // One single AHB-Lite transfer: address phase, then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      timed_out("bus");
    end
  endtask : bus

  // Write, then one idle cycle so a following read sees the new value
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    bus(1'b1, a, d, junk);
    @(posedge hclk);
  endtask : wr

  // Read and compare the masked bits
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    `CHK(what, exp, d & m)
  endtask : rd_chk

  // Reads until the masked bits match, bounded
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, a, 32'h0000_0000, d);
      if ((d & m) === exp) begin
        return;
      end
    end
    timed_out("poll");
  endtask : poll

  // Waits for the sampling pin to reach a level, bounded
  task wait_sample_enable(input logic v);
    for (int i = 0; i < 100; i++) begin
      @(posedge hclk);
      if (sampling === v) begin
        return;
      end
    end
    timed_out("sampling");
  endtask : wait_sample_enable

  // A clean rising edge on the trigger pin
  task pulse_trig;
    trigger_in <= 1'b1;
    repeat (4) @(posedge hclk);
    trigger_in <= 1'b0;
    @(posedge hclk);
  endtask : pulse_trig

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and unmapped space
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, ascc_pkg::CTRL_RESET, "ctrl reset");
    rd_chk(ascc_pkg::OFS_IRQ_STAT, 32'hffff_ffff, 32'h0000_0000, "status reset");
    rd_chk(ascc_pkg::OFS_CONV_CFG, 32'hffff_ffff, {28'h000_0000, ascc_pkg::SEQ_LEN_RESET}, "cfg reset");
    rd_chk(8'h1c, 32'hffff_ffff, 32'h0000_0000, "unmapped");
    `CHK("sampling reset", 1'b0, sampling)
    `CHK("hresp", 1'b0, hresp)
    $display("test reset done");
    // Unimplemented bit and the alias registers
    wr(ascc_pkg::OFS_CTRL, 32'h0000_0018);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_0010, "ctrl bit3");
    wr(ascc_pkg::OFS_CTRL_SET, 32'h0000_0060);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_0070, "alias set");
    wr(ascc_pkg::OFS_CTRL_CLR, 32'h0000_0030);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_0040, "alias clear");
    wr(ascc_pkg::OFS_CTRL_INV, 32'h0000_00c0);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_0080, "alias invert");
    wr(ascc_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test aliases done");
    // Manual sampling and conversion
    wr(ascc_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    wr(ascc_pkg::OFS_CTRL, 32'h0000_8000);
    `CHK("idle sampling", 1'b0, sampling)
    wr(ascc_pkg::OFS_CTRL, 32'h0000_8002);
    `CHK("sampling on", 1'b1, sampling)
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_8002, "ctrl sampling");
    wr(ascc_pkg::OFS_CTRL, 32'h0000_8000);
    `CHK("sampling off", 1'b0, sampling)
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_8000, "converting");
    poll(ascc_pkg::OFS_CTRL, 32'h0000_0001, 32'h0000_0001);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_8001, "done manual");
    rd_chk(ascc_pkg::OFS_IRQ_STAT, 32'hffff_ffff, 32'h0000_0003, "status");
    `CHK("irq high", 1'b1, irq)
    // Software never writes a one to the done bit: the set alias leaves it alone
    wr(ascc_pkg::OFS_CTRL_SET, 32'h0000_0010);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_8011, "done keep");
    wr(ascc_pkg::OFS_CTRL, 32'h0000_8000);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_8000, "done clear");
    wr(ascc_pkg::OFS_IRQ_STAT, 32'h0000_0003);
    rd_chk(ascc_pkg::OFS_IRQ_STAT, 32'hffff_ffff, 32'h0000_0000, "status clear");
    `CHK("irq low", 1'b0, irq)
    $display("test manual done");
    // Hardware trigger with the stop option, interrupt masked
    wr(ascc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    wr(ascc_pkg::OFS_CTRL, 32'h0000_8022);
    wr(ascc_pkg::OFS_CTRL_SET, 32'h0000_0014);
    rd_chk(ascc_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_8036, "armed");
    pulse_trig();
    wait_sample_enable(1'b0);
    rd_chk(ascc_pkg::OFS_CTRL, 32'h0000_0003, 32'h0000_0000, "trigger clears sample");
    poll(ascc_pkg::OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    rd_chk(ascc_pkg::OFS_CTRL, 32'h0000_00f5, 32'h0000_0031, "stop clears auto");
    `CHK("irq masked", 1'b0, irq)
    wr(ascc_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    // The interrupt pin follows the status one cycle later
    @(posedge hclk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(ascc_pkg::OFS_IRQ_STAT, 32'h0000_0003);
    @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
    wr(ascc_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test stop done");
    // Automatic restart keeps running, done cleared by each new conversion
    wr(ascc_pkg::OFS_CTRL, 32'h0000_8022);
    wr(ascc_pkg::OFS_CTRL_SET, 32'h0000_0004);
    pulse_trig();
    wait_sample_enable(1'b0);
    wait_sample_enable(1'b1);
    rd_chk(ascc_pkg::OFS_CTRL, 32'h0000_0007, 32'h0000_0007, "auto restart");
    pulse_trig();
    wait_sample_enable(1'b0);
    rd_chk(ascc_pkg::OFS_CTRL, 32'h0000_0001, 32'h0000_0000, "done at start");
    wait_sample_enable(1'b1);
    rd_chk(ascc_pkg::OFS_CTRL, 32'h0000_0005, 32'h0000_0005, "second sequence");
    wr(ascc_pkg::OFS_CTRL_CLR, 32'h0000_0001);
    `CHK("sampling undisturbed", 1'b1, sampling)
    rd_chk(ascc_pkg::OFS_CTRL, 32'h0000_0007, 32'h0000_0006, "done cleared");
    wr(ascc_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK("off aborts", 1'b0, sampling)
    $display("test auto done");
    report_and_stop();
  end
endmodule : tb
